// File: logic/event_buffer_control_logic.sv
// Central control logic of the event readout buffer module
// How it works
// - Channels write into the fill buffer number the controller last supplied.
// - A rejected buffer is reused only when the controller reissues its number.
// - Readout comes from the drain buffer number the controller supplies.
// - Fill and drain ports each have their own automatic sequential mode bit.
// - In automatic mode the port number advances itself; controller numbers ignored.
// - Messages written over the VME side enter the same queue as backplane ones.
// - Messages queue in a small FIFO and execute in queue order; a VME write enters ahead of a pending backplane word.
// - Each message word is 8 data bits with a 4-bit identifier.
// - Fill or drain request raises its busy status within 200 ns.
// - Fill start: fetch start and size from shared memory, broadcast to channels.
// - After data arrives, collect channel byte counts and sum into global count.
// - The global event byte count is presented for the VME master to read.
// - Drain loads DMA with per-channel counts; blocks copied back to back.
// - Filling one buffer and draining another may proceed together.
// - The output path moves one byte per clock, beyond 40 MByte/s.
// - Each channel port takes one byte per clock, beyond 53 MByte/s.
// - Busy and queue-full status lines are driven back to the controller.
// - Early link data waits in channel input FIFOs until the fill begins.
// - Drain emits channels in configured order, skipping disabled channels.
// - Buffer start and size are forced onto 8-byte boundaries.
`timescale 1ns/1ns
`include "evbuf_ctrl_defs.svh"
module event_buffer_control_logic
    import evbuf_ctrl_pkg::*;
#(
    parameter int NCH    = 10,
    parameter int BUF_W  = 8,
    parameter int ADDR_W = 16,
    parameter int CNT_W  = 16,
    parameter int MFIFO  = 8
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  ce_in,
    // Backplane control bus
    input  wire logic                  bp_strobe_in,
    input  wire logic [3:0]            bp_id_in,
    input  wire logic [7:0]            bp_data_in,
    output logic                       fill_busy_out,
    output logic                       drain_busy_out,
    output logic                       msg_full_out,
    // VME control register writes
    input  wire logic                  vme_msg_we_in,
    input  wire logic [3:0]            vme_msg_id_in,
    input  wire logic [7:0]            vme_msg_data_in,
    output logic [CNT_W-1:0]           global_count_out,
    output logic                       global_count_valid_out,
    // Shared parameter memory read port
    output logic                       spm_rd_out,
    output logic [11:0]                spm_addr_out,
    input  wire logic [31:0]           spm_rdata_in,
    input  wire logic                  spm_rvalid_in,
    // Receive controllers
    output logic                       rx_start_out,
    output logic [BUF_W-1:0]           rx_buf_out,
    output logic [ADDR_W-1:0]          rx_base_out,
    output logic [ADDR_W-1:0]          rx_size_out,
    input  wire logic [NCH-1:0]        rx_done_in,
    input  wire logic [NCH*CNT_W-1:0]  rx_count_in,
    // Drain configuration
    input  wire logic [NCH-1:0]        ch_enable_in,
    input  wire logic [NCH*4-1:0]      ch_order_in,
    // DMA byte stream towards the VME output FIFO
    output logic [BUF_W-1:0]           dma_buf_out,
    output logic [3:0]                 dma_ch_out,
    output logic [CNT_W-1:0]           dma_offset_out,
    input  wire logic [7:0]            dma_byte_in,
    output logic                       ofifo_valid_out,
    output logic [7:0]                 ofifo_data_out,
    input  wire logic                  ofifo_ready_in
);
    initial begin
        if (NCH < 1 || NCH > 16) $error("NCH must be 1..16");
        if (`BUSY_LIMIT_CYC < 3) $error("Busy limit too short for pipeline");
    end

    // ****************************************************************
    // Reset and pin synchronisers
    // ****************************************************************
    logic rst_s1_reg, rst_reg;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_reg <= 1'b0;
            rst_reg    <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_reg    <= rst_s1_reg;
        end
    end
    wire rst_b = rst_reg;

    // Backplane pins come from another module, so they pass two flops
    logic [12:0] bp_s1_reg, bp_s2_reg;
    logic        bp_prev_reg;
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            bp_s1_reg   <= '0;
            bp_s2_reg   <= '0;
            bp_prev_reg <= 1'b0;
        end else if (ce_in) begin
            bp_s1_reg   <= {bp_strobe_in, bp_id_in, bp_data_in};
            bp_s2_reg   <= bp_s1_reg;
            bp_prev_reg <= bp_s2_reg[12];
        end
    end
    wire bp_push = bp_s2_reg[12] && !bp_prev_reg;

    // ****************************************************************
    // Message queue
    // ****************************************************************
    // VME write wins a same-cycle tie; the backplane word is taken in the first cycle without a VME write
    logic        bp_hold_reg;
    logic [11:0] bp_word_reg;
    wire         q_push = vme_msg_we_in || bp_push || bp_hold_reg;
    wire  [11:0] q_wdata = vme_msg_we_in ? {vme_msg_id_in, vme_msg_data_in} :
                           bp_hold_reg ? bp_word_reg : bp_s2_reg[11:0];
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            bp_hold_reg <= 1'b0;
            bp_word_reg <= '0;
        end else if (ce_in) begin
            bp_hold_reg <= vme_msg_we_in && (bp_push || bp_hold_reg);
            if (bp_push) bp_word_reg <= bp_s2_reg[11:0];
        end
    end

    logic [11:0] q_rdata;
    logic        q_empty, q_full;
    wire         q_pop;
    msg_fifo #(.WIDTH(12), .DEPTH(MFIFO)) u_fifo (
        .clk_in    (clk_sys_in),
        .rst_b_in  (rst_b),
        .ce_in     (ce_in),
        .push_in   (q_push),
        .data_in   (q_wdata),
        .pop_in    (q_pop),
        .data_out  (q_rdata),
        .empty_out (q_empty),
        .full_out  (q_full)
    );
    wire [3:0] m_id   = q_rdata[11:8];
    wire [7:0] m_data = q_rdata[7:0];

    // ****************************************************************
    // Message decode
    // ****************************************************************
    fill_state_e  fs_reg;
    drain_state_e ds_reg;
    logic         fill_auto_reg, drain_auto_reg;
    logic [BUF_W-1:0] fill_buf_reg, drain_buf_reg;
    // A request waits at the queue head while its port is busy, keeping order
    wire is_fill  = (m_id == `ID_FILL_REQ);
    wire is_drain = (m_id == `ID_DRAIN_REQ);
    wire is_done  = (m_id == `ID_FILL_DONE);
    wire is_cfg   = (m_id == `ID_CFG);
    wire stall    = (is_fill && fs_reg != FS_IDLE) || (is_drain && ds_reg != DS_IDLE) ||
                    (is_done && fs_reg != FS_WAIT);
    assign q_pop  = !q_empty && !stall;
    wire take_fill  = q_pop && is_fill;
    wire take_drain = q_pop && is_drain;
    wire take_done  = q_pop && is_done;

    // Mode bits and buffer numbers
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            fill_auto_reg  <= 1'b0;
            drain_auto_reg <= 1'b0;
            fill_buf_reg   <= '0;
            drain_buf_reg  <= '0;
        end else if (ce_in) begin
            if (q_pop && is_cfg) begin
                fill_auto_reg  <= m_data[`CFG_FILL_AUTO];
                drain_auto_reg <= m_data[`CFG_DRAIN_AUTO];
            end
            if (take_fill)
                fill_buf_reg <= fill_auto_reg ? BUF_W'(fill_buf_reg + 1'b1) : BUF_W'(m_data);
            if (take_drain)
                drain_buf_reg <= drain_auto_reg ? BUF_W'(drain_buf_reg + 1'b1) : BUF_W'(m_data);
        end
    end

    // ****************************************************************
    // Fill sequencer
    // ****************************************************************
    logic [ADDR_W-1:0] base_reg, size_reg;
    logic [CNT_W-1:0]  sum_reg;
    logic [3:0]        sum_idx_reg;
    wire  [CNT_W-1:0]  cnt_sel = rx_count_in[sum_idx_reg*CNT_W +: CNT_W];
    wire  [ADDR_W-1:0] align_mask = ~ADDR_W'((1 << `ALIGN_BITS) - 1);
    wire  [11:0]       tbl_addr = `TBL_BASE + {3'h0, fill_buf_reg, 1'b0};
    wire               sum_last = (sum_idx_reg == 4'(NCH - 1));

    // Fill-side state; the channels' input FIFOs hold early data until rx_start
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            fs_reg      <= FS_IDLE;
            base_reg    <= '0;
            size_reg    <= '0;
            sum_reg     <= '0;
            sum_idx_reg <= '0;
        end else if (ce_in) begin
            unique case (fs_reg)
                FS_IDLE:     if (take_fill) fs_reg <= FS_RD_START;
                FS_RD_START: if (spm_rvalid_in) begin
                    base_reg <= spm_rdata_in[ADDR_W-1:0] & align_mask;
                    fs_reg   <= FS_RD_SIZE;
                end
                FS_RD_SIZE:  if (spm_rvalid_in) begin
                    size_reg <= spm_rdata_in[ADDR_W-1:0] & align_mask;
                    fs_reg   <= FS_BCAST;
                end
                FS_BCAST:    fs_reg <= FS_WAIT;
                FS_WAIT:     if (take_done || &rx_done_in) begin
                    sum_reg     <= '0;
                    sum_idx_reg <= '0;
                    fs_reg      <= FS_SUM;
                end
                FS_SUM: begin
                    sum_reg     <= sum_reg + cnt_sel;
                    sum_idx_reg <= sum_idx_reg + 1'b1;
                    if (sum_last) fs_reg <= FS_IDLE;
                end
            endcase
        end
    end

    // Registered outputs toward shared memory, channels and the scanner
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            spm_rd_out             <= 1'b0;
            spm_addr_out           <= '0;
            rx_start_out           <= 1'b0;
            rx_buf_out             <= '0;
            rx_base_out            <= '0;
            rx_size_out            <= '0;
            global_count_out       <= '0;
            global_count_valid_out <= 1'b0;
        end else if (ce_in) begin
            spm_rd_out   <= (fs_reg == FS_RD_START && !spm_rvalid_in) ||
                            (fs_reg == FS_RD_SIZE && !spm_rvalid_in);
            spm_addr_out <= (fs_reg == FS_RD_SIZE) ? tbl_addr + 12'h001 : tbl_addr;
            rx_start_out <= (fs_reg == FS_BCAST);
            if (fs_reg == FS_BCAST) begin
                rx_buf_out  <= fill_buf_reg;
                rx_base_out <= base_reg;
                rx_size_out <= size_reg;
            end
            if (take_fill) global_count_valid_out <= 1'b0;
            if (fs_reg == FS_SUM && sum_last) begin
                global_count_out       <= sum_reg + cnt_sel;
                global_count_valid_out <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Drain DMA, independent of the fill sequencer
    // ****************************************************************
    logic [3:0]       slot_reg;
    logic [CNT_W-1:0] left_reg;
    wire  [3:0]       slot_ch  = ch_order_in[slot_reg*4 +: 4];
    wire              slot_ok  = ch_enable_in[slot_ch] && (rx_count_in[slot_ch*CNT_W +: CNT_W] != '0);
    wire              last_slot = (slot_reg == 4'(NCH - 1));
    wire              beat     = ds_reg == DS_COPY && (!ofifo_valid_out || ofifo_ready_in);

    // One byte per clock gives 250 MByte/s on both sides
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            ds_reg          <= DS_IDLE;
            slot_reg        <= '0;
            left_reg        <= '0;
            dma_buf_out     <= '0;
            dma_ch_out      <= '0;
            dma_offset_out  <= '0;
            ofifo_valid_out <= 1'b0;
            ofifo_data_out  <= '0;
        end else if (ce_in) begin
            if (ofifo_ready_in) ofifo_valid_out <= 1'b0;
            unique case (ds_reg)
                DS_IDLE: if (take_drain) begin
                    slot_reg <= '0;
                    ds_reg   <= DS_LOAD;
                end
                DS_LOAD: begin
                    dma_buf_out <= drain_buf_reg;
                    if (slot_ok) begin
                        dma_ch_out     <= slot_ch;
                        dma_offset_out <= '0;
                        left_reg       <= rx_count_in[slot_ch*CNT_W +: CNT_W];
                        ds_reg         <= DS_COPY;
                    end else if (last_slot) ds_reg <= DS_IDLE;
                    else slot_reg <= slot_reg + 1'b1;
                end
                DS_COPY: if (beat) begin
                    ofifo_valid_out <= 1'b1;
                    ofifo_data_out  <= dma_byte_in;
                    dma_offset_out  <= dma_offset_out + 1'b1;
                    left_reg        <= left_reg - 1'b1;
                    if (left_reg == CNT_W'(1)) begin
                        slot_reg <= slot_reg + 1'b1;
                        ds_reg   <= last_slot ? DS_IDLE : DS_LOAD;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Status toward the controller
    // ****************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_b) begin
        if (!rst_b) begin
            fill_busy_out  <= 1'b0;
            drain_busy_out <= 1'b0;
            msg_full_out   <= 1'b0;
        end else if (ce_in) begin
            fill_busy_out  <= take_fill || fs_reg != FS_IDLE;
            drain_busy_out <= take_drain || ds_reg != DS_IDLE;
            msg_full_out   <= q_full;
        end
    end
endmodule : event_buffer_control_logic

// File: logic/evbuf_ctrl_defs.svh
// Constants for the event buffer control logic
`ifndef EVBUF_CTRL_DEFS_SVH
`define EVBUF_CTRL_DEFS_SVH

// ****************************************************************
// Message identifiers
// ****************************************************************
`define ID_FILL_REQ      4'h1
`define ID_DRAIN_REQ     4'h2
`define ID_FILL_DONE     4'h3
`define ID_CFG           4'h4
// Config word bit positions
`define CFG_FILL_AUTO    0
`define CFG_DRAIN_AUTO   1
// Timing
`define BUSY_LIMIT_NS    200
`define CLK_PERIOD_NS    4
`define BUSY_LIMIT_CYC   (`BUSY_LIMIT_NS / `CLK_PERIOD_NS)
// Shared memory layout: table of start/size pairs, words of 4 bytes
`define TBL_BASE         12'h000
`define ALIGN_BITS       3

`endif

// File: logic/evbuf_ctrl_pkg.sv
// Types for the event buffer control logic
package evbuf_ctrl_pkg;
    typedef enum logic [2:0] {
        FS_IDLE, FS_RD_START, FS_RD_SIZE, FS_BCAST, FS_WAIT, FS_SUM
    } fill_state_e;
    typedef enum logic [1:0] {
        DS_IDLE, DS_LOAD, DS_COPY
    } drain_state_e;
endpackage : evbuf_ctrl_pkg

// File: logic/msg_fifo.sv
// Small first-in first-out store for controller messages
`timescale 1ns/1ns
module msg_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             ce_in,
    input  wire logic             push_in,
    input  wire logic [WIDTH-1:0] data_in,
    input  wire logic             pop_in,
    output logic      [WIDTH-1:0] data_out,
    output logic                  empty_out,
    output logic                  full_out
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    wire              do_push = push_in && !full_out;
    wire              do_pop  = pop_in && !empty_out;

    // Storage and pointers; arrival order is kept by plain ring pointers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (ce_in) begin
            if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (ce_in && do_push) mem_reg[wr_ptr_reg[AW-1:0]] <= data_in;
    end

    assign data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
    assign empty_out = (wr_ptr_reg == rd_ptr_reg);
    assign full_out  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
endmodule : msg_fifo

// File: verification/event_buffer_control_logic_assertions.sv
// Port-level assertions for the event buffer control logic
`timescale 1ns/1ns
`include "evbuf_ctrl_defs.svh"
module evbuf_ctrl_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk_sys_in,
    input wire logic              rst_b_in,
    input wire logic              vme_msg_we_in,
    input wire logic [3:0]        vme_msg_id_in,
    input wire logic              fill_busy_out,
    input wire logic              drain_busy_out,
    input wire logic              global_count_valid_out,
    input wire logic              spm_rd_out,
    input wire logic              spm_rvalid_in,
    input wire logic [11:0]       spm_addr_out,
    input wire logic              rx_start_out,
    input wire logic [ADDR_W-1:0] rx_base_out,
    input wire logic [ADDR_W-1:0] rx_size_out,
    input wire logic              ofifo_valid_out,
    input wire logic              ofifo_ready_in,
    input wire logic [7:0]        ofifo_data_out
);
    // ****************************************
    // Assertions
    // ****************************************
    localparam int BUSY_CYC = `BUSY_LIMIT_CYC;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    property p_fill_busy_rise;
        vme_msg_we_in && vme_msg_id_in == `ID_FILL_REQ && !fill_busy_out |-> ##[1:BUSY_CYC] fill_busy_out;
    endproperty
    a_fill_busy_rise: assert property (p_fill_busy_rise) else $error("fill busy late");
    property p_drain_busy_rise;
        vme_msg_we_in && vme_msg_id_in == `ID_DRAIN_REQ && !drain_busy_out |-> ##[1:BUSY_CYC] drain_busy_out;
    endproperty
    a_drain_busy_rise: assert property (p_drain_busy_rise) else $error("drain busy late");
    property p_start_pulse;
        rx_start_out |=> !rx_start_out;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_start_in_fill;
        rx_start_out |-> fill_busy_out && !global_count_valid_out;
    endproperty
    a_start_in_fill: assert property (p_start_in_fill) else $error("start outside fill");
    property p_align;
        rx_start_out |-> rx_base_out[2:0] == 3'h0 && rx_size_out[2:0] == 3'h0;
    endproperty
    a_align: assert property (p_align) else $error("buffer not aligned");
    property p_size_then_start;
        spm_rd_out && spm_rvalid_in && spm_addr_out[0] |-> ##[1:3] rx_start_out;
    endproperty
    a_size_then_start: assert property (p_size_then_start) else $error("no start after size");
    property p_sum_done;
        $rose(global_count_valid_out) |-> ##[0:2] !fill_busy_out;
    endproperty
    a_sum_done: assert property (p_sum_done) else $error("fill busy stuck");
    property p_ofifo_hold;
        ofifo_valid_out && !ofifo_ready_in |=> ofifo_valid_out && $stable(ofifo_data_out);
    endproperty
    a_ofifo_hold: assert property (p_ofifo_hold) else $error("output byte dropped");
endmodule : evbuf_ctrl_checker

bind event_buffer_control_logic evbuf_ctrl_checker #(.ADDR_W(ADDR_W)) i_evbuf_ctrl_checker (
    .clk_sys_in, .rst_b_in, .vme_msg_we_in, .vme_msg_id_in, .fill_busy_out, .drain_busy_out,
    .global_count_valid_out, .spm_rd_out, .spm_rvalid_in, .spm_addr_out, .rx_start_out, .rx_base_out,
    .rx_size_out, .ofifo_valid_out, .ofifo_ready_in, .ofifo_data_out
);

// File: verification/sys_ctrl_model.sv
// Behavioural system controller on the backplane message bus
`timescale 1ns/1ns
module sys_ctrl_model (
    input  wire logic clk_in,
    output logic      strobe_out,
    output logic [3:0] id_out,
    output logic [7:0] data_out
);
    // ****************************************
    // Message sender
    // ****************************************
    initial begin
        strobe_out = 1'h0;
        id_out     = 4'h5;
        data_out   = 8'hA5;
    end
    // Strobe held four cycles and the word eight so the two-flop synchroniser sees a clean level
    task automatic send(input logic [3:0] id, input logic [7:0] data);
        @(negedge clk_in);
        id_out     = id;
        data_out   = data;
        strobe_out = 1'h1;
        repeat (4) @(negedge clk_in);
        strobe_out = 1'h0;
        repeat (4) @(negedge clk_in);
        // Released lines carry the inverse so a late sample shows up
        id_out     = ~id;
        data_out   = ~data;
    endtask : send
endmodule : sys_ctrl_model

// File: verification/event_buffer_control_logic_tb.sv
// Self-checking bench for the event buffer control logic
`timescale 1ns/1ns
`include "evbuf_ctrl_defs.svh"
module event_buffer_control_logic_tb;
    localparam int NCH = 10;
    logic         clk_sys_in = 1'h0, rst_b_in = 1'h0, ce_in = 1'h1, vme_msg_we_in = 1'h0, started = 1'h0;
    logic         spm_rvalid_in = 1'h0, ofifo_ready_in = 1'h0, bp_strobe_in, spm_rd_out, rx_start_out;
    logic         fill_busy_out, drain_busy_out, msg_full_out, global_count_valid_out, ofifo_valid_out;
    logic [3:0]   bp_id_in, vme_msg_id_in = 4'h0, dma_ch_out;
    logic [7:0]   bp_data_in, vme_msg_data_in = 8'h00, rx_buf_out, dma_buf_out, dma_byte_in, ofifo_data_out;
    logic [11:0]  spm_addr_out;
    logic [15:0]  global_count_out, rx_base_out, rx_size_out, dma_offset_out;
    logic [31:0]  spm_rdata_in = 32'h0;
    logic [9:0]   rx_done_in = 10'h000, ch_enable_in = 10'h000;
    logic [39:0]  ch_order_in = 40'h0;
    logic [159:0] rx_count_in = 160'h0;
    logic [31:0]  spm [0:511];
    logic [11:0]  addrs[$];
    logic [7:0]   got[$];
    logic [7:0]   fbuf = 8'h00, dbuf = 8'h00;
    bit           fauto = 1'h0, dauto = 1'h0;
    int           cnt[NCH];
    int           n_mismatch = 0, num_checks = 0, cyc = 0;

    // Device under test
    event_buffer_control_logic i_event_buffer_control_logic (
        .clk_sys_in, .rst_b_in, .ce_in, .bp_strobe_in, .bp_id_in, .bp_data_in, .fill_busy_out, .drain_busy_out,
        .msg_full_out, .vme_msg_we_in, .vme_msg_id_in, .vme_msg_data_in, .global_count_out,
        .global_count_valid_out, .spm_rd_out, .spm_addr_out, .spm_rdata_in, .spm_rvalid_in, .rx_start_out,
        .rx_buf_out, .rx_base_out, .rx_size_out, .rx_done_in, .rx_count_in, .ch_enable_in, .ch_order_in,
        .dma_buf_out, .dma_ch_out, .dma_offset_out, .dma_byte_in, .ofifo_valid_out, .ofifo_data_out,
        .ofifo_ready_in
    );
    sys_ctrl_model i_sys_ctrl_model (.clk_in(clk_sys_in), .strobe_out(bp_strobe_in), .id_out(bp_id_in),
                                     .data_out(bp_data_in));

    always #2 clk_sys_in = ~clk_sys_in;
    // ****************************************
    // Far side: memories, output sink, timeout
    // ****************************************
    // Buffer memory is combinational; each byte encodes buffer, channel and offset
    assign dma_byte_in = dma_buf_out ^ {dma_ch_out, 4'h0} ^ dma_offset_out[7:0];
    // Shared memory answers every other cycle; idle read data is inverted so stale use shows
    always @(negedge clk_sys_in) begin
        ofifo_ready_in <= ($urandom % 4) != 0;
        spm_rvalid_in  <= spm_rd_out && !spm_rvalid_in;
        spm_rdata_in   <= (spm_rd_out && !spm_rvalid_in) ? spm[spm_addr_out[8:0]] : ~spm_rdata_in;
        if (spm_rd_out && !spm_rvalid_in)
            addrs.push_back(spm_addr_out);
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (rx_start_out) started = 1'h1;
        if (ce_in && ofifo_valid_out && ofifo_ready_in) got.push_back(ofifo_data_out);
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_for(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 500) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("wait", 32'h1, 32'(n < 500));
    endtask : wait_for
    task automatic vme(input logic [3:0] id, input logic [7:0] data);
        @(negedge clk_sys_in);
        vme_msg_we_in   = 1'h1;
        vme_msg_id_in   = id;
        vme_msg_data_in = data;
        @(negedge clk_sys_in);
        vme_msg_we_in   = 1'h0;
        vme_msg_id_in   = ~id;
        vme_msg_data_in = ~data;
    endtask : vme
    task automatic fill_start(input logic [7:0] d, input bit bp);
        fbuf = fauto ? fbuf + 8'h01 : d;
        addrs = {};
        started = 1'h0;
        if (bp)
            i_sys_ctrl_model.send(`ID_FILL_REQ, d);
        else
            vme(`ID_FILL_REQ, d);
        wait_for(started, 1'h1);
        check("fill busy", 32'h1, fill_busy_out);
        check("fill buffer", fbuf, rx_buf_out);
        check("start addr", {fbuf, 1'h0}, addrs[0]);
        check("size addr", {fbuf, 1'h1}, addrs[1]);
        check("base", spm[{fbuf, 1'h0}][15:0] & 16'hFFF8, rx_base_out);
        check("size", spm[{fbuf, 1'h1}][15:0] & 16'hFFF8, rx_size_out);
    endtask : fill_start
    task automatic fill_end();
        int sum = 0;
        foreach (cnt[c]) begin
            cnt[c] = $urandom % 7;
            rx_count_in[c*16 +: 16] = 16'(cnt[c]);
            sum += cnt[c];
        end
        rx_done_in = 10'h3FF;
        wait_for(global_count_valid_out, 1'h1);
        check("global count", sum, global_count_out);
        rx_done_in = 10'h000;
        wait_for(fill_busy_out, 1'h0);
        $display("test fill done");
    endtask : fill_end
    task automatic drain(input logic [7:0] d, input bit bp);
        logic [7:0] exp[$];
        int c;
        dbuf = dauto ? dbuf + 8'h01 : d;
        for (int s = 0; s < NCH; s++) begin
            c = int'(ch_order_in[s*4 +: 4]);
            if (ch_enable_in[c])
                for (int k = 0; k < cnt[c]; k++)
                    exp.push_back(dbuf ^ {c[3:0], 4'h0} ^ k[7:0]);
        end
        got = {};
        if (bp)
            i_sys_ctrl_model.send(`ID_DRAIN_REQ, d);
        else
            vme(`ID_DRAIN_REQ, d);
        wait_for(drain_busy_out, 1'h1);
        ce_in = 1'h0;
        repeat (3) @(negedge clk_sys_in);
        ce_in = 1'h1;
        wait_for(drain_busy_out, 1'h0);
        wait_for(ofifo_valid_out, 1'h0);
        check("byte total", exp.size(), got.size());
        foreach (exp[i])
            check("drained byte", exp[i], got[i]);
        $display("test drain done");
    endtask : drain
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // ****************************************
    // Main sequence
    // ****************************************
    // Drain order is a fixed permutation so skipped channels change the stream visibly
    initial begin
        void'($urandom(91624));
        foreach (spm[i])
            spm[i] = $urandom;
        for (int s = 0; s < NCH; s++)
            ch_order_in[s*4 +: 4] = 4'((s * 3 + 1) % NCH);
        ch_enable_in = 10'($urandom) | 10'h001;
        repeat (5) @(negedge clk_sys_in);
        rst_b_in = 1'h1;
        repeat (3) @(negedge clk_sys_in);
        check("idle fill busy", 32'h0, fill_busy_out);
        check("idle drain busy", 32'h0, drain_busy_out);
        fill_start(8'($urandom), 1'h0);
        fill_end();
        fill_start(fbuf, 1'h1);
        fill_end();
        drain(fbuf, 1'h1);
        fill_start(fbuf + 8'h01, 1'h0);
        drain(fbuf - 8'h01, 1'h0);
        fill_end();
        vme(`ID_CFG, 8'h03);
        fauto = 1'h1;
        dauto = 1'h1;
        repeat (2) begin
            fill_start(8'($urandom), 1'h0);
            fill_end();
            drain(8'($urandom), 1'h0);
        end
        repeat (8) vme(`ID_FILL_DONE, 8'h00);
        wait_for(msg_full_out, 1'h1);
        end_sim();
    end
endmodule : event_buffer_control_logic_tb
